// *** rtl/pdc_pkg.sv ***
// Constants shared by the power-down controller files.
package pdc_pkg;
    localparam logic [7:0] PDC_PWR_CFG_ADDR  = 8'h87;
    localparam int         PDC_IDLE_BIT      = 0;
    localparam int         PDC_PD_BIT        = 1;
    localparam int         PDC_FLAG_LOW_BIT  = 2;
    localparam int         PDC_FLAG_HIGH_BIT = 3;
    localparam logic [3:0] PDC_CFG_RESET     = 4'h0;
    localparam logic [7:0] PDC_RSVD_READ     = 8'h00;
    localparam int         PDC_CLK_MHZ       = 20;
    localparam int         PDC_OSC_STABLE_US = 1000;
    localparam int         PDC_OSC_CYCLES    = PDC_OSC_STABLE_US * PDC_CLK_MHZ;
    localparam int         PDC_RESET_RUN_CYCLES = 24;
    typedef enum logic [4:0] {
        PDC_RUN      = 5'b00001,
        PDC_IDLE     = 5'b00010,
        PDC_PDOWN    = 5'b00100,
        PDC_OSC_WAIT = 5'b01000,
        PDC_RELEASE  = 5'b10000
    } pdc_state_type;
endpackage

// *** rtl/pdc_sync.sv ***
// Two-flop synchroniser for asynchronous inputs.
`timescale 1ns/1ps
module pdc_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    // Clock and reset.
    input  wire logic             clk_sys,
    input  wire logic             nrst,
    // Data.
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            meta_q <= INIT;
            dout   <= INIT;
        end else begin
            meta_q <= din;
            dout   <= meta_q;
        end
    end
endmodule

// *** rtl/pdc_counter.sv ***
// Down counter that reports when a loaded count has elapsed.
`timescale 1ns/1ps
module pdc_counter #(
    parameter int WIDTH = 16
) (
    // Clock and reset.
    input  wire logic             clk_sys,
    input  wire logic             rst_n,
    // Control.
    input  wire logic             load,
    input  wire logic [WIDTH-1:0] count,
    input  wire logic             run,
    output logic                  done
);
    logic [WIDTH-1:0] cnt_q;

    // Elaboration check: a one-bit counter cannot tell a load from done.
    if (WIDTH < 2) begin : g_bad_width
        $error("pdc_counter: WIDTH too small");
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= '0;
            done  <= 1'b0;
        end else if (load) begin
            cnt_q <= count;
            done  <= 1'b0;
        end else if (run && cnt_q != '0) begin
            cnt_q <= cnt_q - 1'b1;
            done  <= (cnt_q == {{(WIDTH-1){1'b0}}, 1'b1});
        end else begin
            done  <= 1'b0;
        end
    end
endmodule

// *** rtl/pdc_power_down_controller.sv ***
// Power configuration register and idle / power-down sequencer.
`timescale 1ns/1ps
module pdc_power_down_controller
    import pdc_pkg::*;
#(
    parameter int OSC_CYCLES = pdc_pkg::PDC_OSC_CYCLES,
    parameter int RESET_RUN  = pdc_pkg::PDC_RESET_RUN_CYCLES
) (
    // Clock and reset.
    clk_sys,
    nrst,
    // Reset pin, active high as on the device.
    rst_pin,
    // External wake lines, active low, and their active-high enables.
    external_wake_line_a_n,
    external_wake_line_b_n,
    wake_enable_a,
    wake_enable_b,
    // Register access from the CPU.
    sfr_addr,
    sfr_wr,
    sfr_rd,
    sfr_wdata,
    sfr_rdata,
    instr_done,
    // Clock gating and core control.
    osc_enable,
    cpu_clk_en,
    periph_clk_en,
    cpu_hold,
    wake_irq,
    reset_run,
    ram_block,
    core_reset,
    powerdown_request,
    idle_request
);
    import pdc_pkg::*;

    localparam int CW = (OSC_CYCLES > RESET_RUN ? $clog2(OSC_CYCLES + 1)
                                                : $clog2(RESET_RUN + 1)) + 1;

    input  wire logic       clk_sys;
    input  wire logic       nrst;
    input  wire logic       rst_pin;
    input  wire logic       external_wake_line_a_n;
    input  wire logic       external_wake_line_b_n;
    input  wire logic       wake_enable_a;
    input  wire logic       wake_enable_b;
    input  wire logic [7:0] sfr_addr;
    input  wire logic       sfr_wr;
    input  wire logic       sfr_rd;
    input  wire logic [7:0] sfr_wdata;
    output logic      [7:0] sfr_rdata;
    input  wire logic       instr_done;
    output logic            osc_enable;
    output logic            cpu_clk_en;
    output logic            periph_clk_en;
    output logic            cpu_hold;
    output logic            wake_irq;
    output logic            reset_run;
    output logic            ram_block;
    output logic            core_reset;
    output logic            powerdown_request;
    output logic            idle_request;

    // Elaboration check: a zero count would never raise the done pulse.
    if (OSC_CYCLES < 1 || RESET_RUN < 1) begin : g_bad_counts
        $error("pdc: counts must be positive");
    end

    logic          rst_n_meta_q;
    logic          rst_n_q;
    logic [2:0]    pins_s;
    logic          rst_pin_s;
    logic          wake_a_s;
    logic          wake_b_s;
    logic          rst_pin_d1_q;
    pdc_state_type state_q;
    pdc_state_type state_d;
    logic          cnt_load;
    logic [CW-1:0] cnt_value;
    logic          cnt_done;
    logic          pd_pend_q;
    logic          idle_pend_q;
    logic          flag_high_q;
    logic          flag_low_q;
    logic          cfg_wr;
    logic          wake_level;
    logic          rst_edge;
    logic          reset_wait_q;

    // Reset release through two flops.
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rst_n_meta_q <= 1'b0;
            rst_n_q      <= 1'b0;
        end else begin
            rst_n_meta_q <= 1'b1;
            rst_n_q      <= rst_n_meta_q;
        end
    end

    pdc_sync #(
        .WIDTH (3),
        .INIT  (3'b110)
    ) u_sync (
        .clk_sys (clk_sys),
        .nrst    (rst_n_q),
        .din     ({external_wake_line_b_n, external_wake_line_a_n, rst_pin}),
        .dout    (pins_s)
    );

    assign rst_pin_s = pins_s[0];
    assign wake_a_s  = ~pins_s[1] & wake_enable_a;
    assign wake_b_s  = ~pins_s[2] & wake_enable_b;
    // Level sensing: either enabled line held low counts as wake.
    assign wake_level = wake_a_s | wake_b_s;
    assign rst_edge   = rst_pin_s & ~rst_pin_d1_q;
    assign cfg_wr     = sfr_wr && (sfr_addr == PDC_PWR_CFG_ADDR);

    always_ff @(posedge clk_sys or negedge rst_n_q) begin
        if (!rst_n_q) begin
            rst_pin_d1_q <= 1'b0;
        end else begin
            rst_pin_d1_q <= rst_pin_s;
        end
    end

    // The bits written take effect once the writing instruction retires.
    always_ff @(posedge clk_sys or negedge rst_n_q) begin
        if (!rst_n_q) begin
            pd_pend_q   <= 1'b0;
            idle_pend_q <= 1'b0;
        end else if (cfg_wr) begin
            pd_pend_q   <= sfr_wdata[PDC_PD_BIT];
            idle_pend_q <= sfr_wdata[PDC_IDLE_BIT];
        end else if (instr_done || rst_pin_s) begin
            pd_pend_q   <= 1'b0;
            idle_pend_q <= 1'b0;
        end
    end

    // Flags are plain storage; reserved bits are never stored.
    always_ff @(posedge clk_sys or negedge rst_n_q) begin
        if (!rst_n_q) begin
            flag_high_q <= PDC_CFG_RESET[PDC_FLAG_HIGH_BIT];
            flag_low_q  <= PDC_CFG_RESET[PDC_FLAG_LOW_BIT];
        end else if (rst_edge) begin
            flag_high_q <= PDC_CFG_RESET[PDC_FLAG_HIGH_BIT];
            flag_low_q  <= PDC_CFG_RESET[PDC_FLAG_LOW_BIT];
        end else if (cfg_wr) begin
            flag_high_q <= sfr_wdata[PDC_FLAG_HIGH_BIT];
            flag_low_q  <= sfr_wdata[PDC_FLAG_LOW_BIT];
        end
    end

    // Sequencer next state.
    always_comb begin
        state_d   = state_q;
        cnt_load  = 1'b0;
        cnt_value = '0;
        case (state_q)
            PDC_RUN: begin
                if (pd_pend_q && instr_done) begin
                    state_d = PDC_PDOWN;
                end else if (idle_pend_q && instr_done) begin
                    state_d = PDC_IDLE;
                end
            end
            PDC_IDLE: begin
                if (rst_pin_s || wake_level) begin
                    state_d = PDC_RUN;
                end
            end
            PDC_PDOWN: begin
                if (rst_pin_s || wake_level) begin
                    state_d   = PDC_OSC_WAIT;
                    cnt_load  = 1'b1;
                    cnt_value = CW'(OSC_CYCLES);
                end
            end
            PDC_OSC_WAIT: begin
                if (cnt_done) begin
                    state_d = PDC_RELEASE;
                end
            end
            PDC_RELEASE: begin
                if (rst_pin_s || !wake_level) begin
                    state_d = PDC_RUN;
                end
            end
            default: begin
                state_d = PDC_RUN;
            end
        endcase
        // The brief run starts whenever a reset wake hands control back to the core.
        if (state_d == PDC_RUN && (rst_edge || (reset_wait_q && state_q == PDC_RELEASE))) begin
            cnt_load  = 1'b1;
            cnt_value = CW'(RESET_RUN);
        end
    end

    pdc_counter #(
        .WIDTH (CW)
    ) u_cnt (
        .clk_sys (clk_sys),
        .rst_n   (rst_n_q),
        .load    (cnt_load),
        .count   (cnt_value),
        .run     (1'b1),
        .done    (cnt_done)
    );

    always_ff @(posedge clk_sys or negedge rst_n_q) begin
        if (!rst_n_q) begin
            state_q <= PDC_RUN;
        end else begin
            state_q <= state_d;
        end
    end

    // After a reset wake the core runs briefly before reset takes over.
    always_ff @(posedge clk_sys or negedge rst_n_q) begin
        if (!rst_n_q) begin
            reset_wait_q <= 1'b0;
        end else if (rst_edge) begin
            reset_wait_q <= 1'b1;
        end else if (cnt_done && state_q == PDC_RUN) begin
            reset_wait_q <= 1'b0;
        end
    end

    // Registered outputs.
    always_ff @(posedge clk_sys or negedge rst_n_q) begin
        if (!rst_n_q) begin
            osc_enable        <= 1'b1;
            cpu_clk_en        <= 1'b1;
            periph_clk_en     <= 1'b1;
            cpu_hold          <= 1'b0;
            wake_irq          <= 1'b0;
            reset_run         <= 1'b0;
            ram_block         <= 1'b0;
            core_reset        <= 1'b0;
            powerdown_request <= 1'b0;
            idle_request      <= 1'b0;
        end else begin
            // Gated clocks park low; core state is held, not cleared.
            osc_enable    <= !(state_d == PDC_PDOWN);
            cpu_clk_en    <= (state_d == PDC_RUN);
            periph_clk_en <= (state_d == PDC_RUN) || (state_d == PDC_IDLE);
            cpu_hold      <= (state_d != PDC_RUN);
            // Interrupt wake raises the service request; no state is reset.
            // A release after a reset wake is not an interrupt and raises no request.
            wake_irq      <= !rst_pin_s && state_d == PDC_RUN &&
                             ((state_q == PDC_RELEASE && !reset_wait_q) ||
                              (state_q == PDC_IDLE && wake_level));
            reset_run     <= reset_wait_q && state_q == PDC_RUN && !cnt_done;
            ram_block     <= reset_wait_q && state_q == PDC_RUN && !cnt_done;
            core_reset    <= reset_wait_q && cnt_done && state_q == PDC_RUN;
            powerdown_request <= (state_d == PDC_PDOWN) || (state_d == PDC_RUN &&
                                 pd_pend_q && !instr_done && !rst_pin_s);
            idle_request  <= (state_d == PDC_IDLE) || (state_d == PDC_RUN &&
                             idle_pend_q && !pd_pend_q && !instr_done &&
                             !rst_pin_s);
        end
    end

    // Register read; reserved upper nibble reads as zero.
    always_ff @(posedge clk_sys or negedge rst_n_q) begin
        if (!rst_n_q) begin
            sfr_rdata <= PDC_RSVD_READ;
        end else if (sfr_rd && sfr_addr == PDC_PWR_CFG_ADDR) begin
            sfr_rdata <= {PDC_RSVD_READ[7:4], flag_high_q, flag_low_q,
                          pd_pend_q, idle_pend_q};
        end else begin
            sfr_rdata <= PDC_RSVD_READ;
        end
    end
endmodule

// *** testbench/pdc_checker.sv ***
// Port assertions for the power-down controller.
`timescale 1ns/1ps
module pdc_checker
    import pdc_pkg::*;
#(
    parameter int OSC_CYCLES = 8,
    parameter int RESET_RUN  = 4
) (
    // Clock, reset and pins.
    input wire logic       clk_sys,
    input wire logic       nrst,
    input wire logic       rst_pin,
    input wire logic       external_wake_line_a_n,
    input wire logic       external_wake_line_b_n,
    // Register reads.
    input wire logic [7:0] sfr_addr,
    input wire logic       sfr_rd,
    input wire logic [7:0] sfr_rdata,
    // Mode outputs.
    input wire logic       osc_enable,
    input wire logic       cpu_clk_en,
    input wire logic       periph_clk_en,
    input wire logic       cpu_hold,
    input wire logic       wake_irq,
    input wire logic       reset_run,
    input wire logic       ram_block,
    input wire logic       core_reset,
    input wire logic       powerdown_request,
    input wire logic       idle_request
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    a_osc_stop_all: assert property (!osc_enable |-> !cpu_clk_en && !periph_clk_en)
        else $error("clocks run with oscillator stopped");
    a_pd_cpu_held: assert property (!osc_enable |-> cpu_hold && powerdown_request)
        else $error("cpu not held in power-down");
    a_idle_cpu_only: assert property (idle_request && cpu_hold |->
        !cpu_clk_en && periph_clk_en && osc_enable)
        else $error("idle clock gating wrong");
    a_wake_clears_req: assert property (wake_irq |-> !powerdown_request && !idle_request)
        else $error("request bit left set on wake");
    a_resume_line_free: assert property (wake_irq && !$past(periph_clk_en) |->
        $past(external_wake_line_a_n && external_wake_line_b_n, 2))
        else $error("resumed while wake line held");
    a_rsvd_read_zero: assert property ($past(sfr_rd) && $past(sfr_addr) == PDC_PWR_CFG_ADDR |->
        sfr_rdata[7:4] == 4'h0)
        else $error("reserved bits read nonzero");
    a_core_reset_end: assert property (core_reset |-> $past(reset_run) ##1 !core_reset)
        else $error("core reset not after brief run");
    a_run_blocks_ram: assert property (reset_run |-> ram_block && cpu_clk_en)
        else $error("ram open during brief run");
    a_pin_clears_pd: assert property ($rose(rst_pin) |-> ##[0:3] !powerdown_request)
        else $error("reset pin did not clear request");
    c_wake: cover property (wake_irq);
    c_core_reset: cover property (core_reset);
    c_idle: cover property (idle_request && periph_clk_en);
endmodule

// *** testbench/pdc_wake_src.sv ***
// Model of the wake interrupt source and the reset circuit.
`timescale 1ns/1ps
module pdc_wake_src #(
    parameter int HOLD = 16
) (
    // Clock.
    input wire logic clk_sys,
    // Pins driven into the device; wake lines idle high on pull-ups.
    output logic     wake_a_n,
    output logic     wake_b_n,
    output logic     rst_pin
);
    initial begin
        wake_a_n = 1'b1;
        wake_b_n = 1'b1;
        rst_pin  = 1'b0;
    end
    // Wake is a level held low, long enough for the oscillator to settle.
    task automatic wake(input bit line_b);
        @(negedge clk_sys);
        if (line_b) wake_b_n = 1'b0;
        else wake_a_n = 1'b0;
        repeat (HOLD) @(negedge clk_sys);
        wake_a_n = 1'b1;
        wake_b_n = 1'b1;
    endtask
    task automatic reset_pulse();
        @(negedge clk_sys);
        rst_pin = 1'b1;
        repeat (HOLD) @(negedge clk_sys);
        rst_pin = 1'b0;
    endtask
endmodule

// *** testbench/tb.sv ***
// Self-checking bench for the power-down controller.
`timescale 1ns/1ps
module tb;
    import pdc_pkg::*;
    localparam int OSC_CYCLES = 8;
    localparam int RESET_RUN  = 4;
    logic       clk_sys, nrst, rst_pin, line_a_n, line_b_n, en_a, en_b;
    logic       sfr_wr, sfr_rd, instr_done, osc_enable, cpu_clk_en, periph_clk_en;
    logic       cpu_hold, wake_irq, reset_run, ram_block, core_reset;
    logic       powerdown_request, idle_request;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, rd_val;
    int         mismatches, checks_done;

    pdc_power_down_controller #(.OSC_CYCLES(OSC_CYCLES), .RESET_RUN(RESET_RUN)) uut (.*,
        .external_wake_line_a_n(line_a_n), .external_wake_line_b_n(line_b_n),
        .wake_enable_a(en_a), .wake_enable_b(en_b));
    pdc_wake_src #(.HOLD(16)) ws (.clk_sys(clk_sys), .wake_a_n(line_a_n),
        .wake_b_n(line_b_n), .rst_pin(rst_pin));

    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    task automatic complete_run();
        if (mismatches == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        chk({7'h00, got}, {7'h00, exp});
    endtask
    function automatic logic pick(input int s);
        case (s)
            0: return osc_enable;
            1: return cpu_clk_en;
            2: return wake_irq;
            3: return reset_run;
            4: return core_reset;
            default: return line_a_n & line_b_n & ~rst_pin;
        endcase
    endfunction
    // Bounded wait, sampled at falling edges where outputs have settled.
    task automatic wt(input int s, input logic v);
        int n;
        n = 0;
        while (pick(s) !== v) begin
            if (++n > 300) begin
                mismatches++;
                complete_run();
            end
            @(negedge clk_sys);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(negedge clk_sys);
        sfr_wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(negedge clk_sys);
        sfr_addr = a;
        sfr_rd = 1'b1;
        @(negedge clk_sys);
        rd_val = sfr_rdata;
        sfr_rd = 1'b0;
    endtask
    task automatic go();
        @(negedge clk_sys);
        instr_done = 1'b1;
        @(negedge clk_sys);
        instr_done = 1'b0;
    endtask
    task automatic t_regs();
        rd(PDC_PWR_CFG_ADDR); chk(rd_val, 8'h00);
        wr(PDC_PWR_CFG_ADDR, 8'hFC); rd(PDC_PWR_CFG_ADDR); chk(rd_val, 8'h0C);
        wr(8'h88, 8'hFF); rd(8'h88); chk(rd_val, 8'h00);
        rd(PDC_PWR_CFG_ADDR); chk(rd_val, 8'h0C);
        chk1(cpu_clk_en, 1'b1);
    endtask
    task automatic t_idle();
        en_a = 1'b1;
        wr(PDC_PWR_CFG_ADDR, 8'h0D); go(); wt(1, 1'b0);
        chk1(periph_clk_en, 1'b1);
        chk1(idle_request, 1'b1);
        fork ws.wake(1'b0); join_none
        wt(2, 1'b1); chk1(idle_request, 1'b0);
        wt(5, 1'b1); rd(PDC_PWR_CFG_ADDR); chk(rd_val, 8'h0C);
    endtask
    task automatic t_pd_wake(input logic [7:0] req, input bit line_b);
        en_a = !line_b;
        en_b = line_b;
        wr(PDC_PWR_CFG_ADDR, req); go(); wt(0, 1'b0);
        chk1(cpu_clk_en, 1'b0);
        chk1(cpu_hold, 1'b1);
        chk1(periph_clk_en, 1'b0);
        chk1(powerdown_request, 1'b1);
        fork ws.wake(line_b); join_none
        wt(2, 1'b1); chk1(line_a_n & line_b_n, 1'b1);
        chk1(powerdown_request, 1'b0);
        wt(5, 1'b1); wt(1, 1'b1); chk1(idle_request, 1'b0);
        rd(PDC_PWR_CFG_ADDR); chk(rd_val, {4'h0, req[3:2], 2'b00});
    endtask
    task automatic t_reset_wake();
        wr(PDC_PWR_CFG_ADDR, 8'h0E); go(); wt(0, 1'b0);
        fork ws.reset_pulse(); join_none
        wt(3, 1'b1); chk1(ram_block, 1'b1);
        wt(4, 1'b1); chk1(osc_enable, 1'b1);
        wt(5, 1'b1); rd(PDC_PWR_CFG_ADDR); chk(rd_val, 8'h00);
    endtask

    initial begin
        mismatches = 0;
        checks_done = 0;
        nrst = 1'b0;
        {en_a, en_b, sfr_wr, sfr_rd, instr_done} = 5'h0_0;
        sfr_addr = 8'h00;
        sfr_wdata = 8'h00;
        repeat (4) @(negedge clk_sys);
        nrst = 1'b1;
        repeat (3) @(negedge clk_sys);
        t_regs();
        t_idle();
        t_pd_wake(8'h06, 1'b1);
        t_pd_wake(8'h0B, 1'b0);
        t_reset_wake();
        complete_run();
    end
endmodule

bind pdc_power_down_controller pdc_checker #(.OSC_CYCLES(OSC_CYCLES),
    .RESET_RUN(RESET_RUN)) chk_i (.*);
